/* File: logic/srcel_defines.svh */
`ifndef SRCEL_DEFINES_SVH
`define SRCEL_DEFINES_SVH

// ============================================================
// Geometry
`define SRCEL_STAGES 4
`define SRCEL_STAGE_RST 4'h0
`define SRCEL_FIFO_DEPTH 16
`define SRCEL_CNT_W 5

// ============================================================
// Register map, byte addresses on the APB port
`define SRCEL_ADDR_W 12
`define SRCEL_OFF_CTRL 12'h000
`define SRCEL_OFF_CMD 12'h004
`define SRCEL_OFF_STAT 12'h008
`define SRCEL_OFF_LEVEL 12'h00C
`define SRCEL_CTRL_SRC_BIT 0
`define SRCEL_CTRL_RST 1'h0
`define SRCEL_WORD_ZERO 32'h0000_0000

// ============================================================
// Command word held in the FIFO
`define SRCEL_CMD_W 6
`define SRCEL_CMD_SER 0
`define SRCEL_CMD_PAR_LO 1
`define SRCEL_CMD_PAR_HI 4
`define SRCEL_CMD_LOAD 5
`define SRCEL_CMD_RST 6'h00

// ============================================================
// Synchronised pin bundle
`define SRCEL_PIN_W 12
`define SRCEL_PIN_RST 12'h080
`define SRCEL_PIN_STROBE 0
`define SRCEL_PIN_SER 1
`define SRCEL_PIN_PAR_LO 2
`define SRCEL_PIN_PAR_HI 5
`define SRCEL_PIN_SLOAD 6
`define SRCEL_PIN_ALOAD_N 7
`define SRCEL_PIN_FREEZE 8
`define SRCEL_PIN_SCAN_IN 9
`define SRCEL_PIN_SCAN_A 10
`define SRCEL_PIN_SCAN_B 11

`endif

/* File: logic/srcel_pkg.sv */
package srcel_pkg;

    typedef enum logic [1:0]
    {
        SRCEL_BUS_IDLE = 2'h0,
        SRCEL_BUS_ACK = 2'h1
    } srcel_bus_state_t;

    typedef logic [3:0] srcel_stage_t;

endpackage : srcel_pkg

/* File: logic/srcel_mem.sv */
`include "srcel_defines.svh"

module srcel_mem
    import srcel_pkg::*;
#(
    parameter int W = `SRCEL_CMD_W,
    parameter int D = `SRCEL_FIFO_DEPTH,
    parameter int AW = $clog2(`SRCEL_FIFO_DEPTH)
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [W-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [W-1:0] rd_data
);

    logic [W-1:0] mem_reg [D];
    logic [W-1:0] rd_data_reg;

    always_ff @(posedge pclk)
    begin
        if (wr_en)
        begin
            mem_reg[wr_addr] <= wr_data;
        end
    end

    // A write to the word being read is passed through, so a FIFO that was empty sees it one cycle later.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_data_reg <= W'(`SRCEL_CMD_RST);
        end
        else
        begin
            rd_data_reg <= (wr_en && wr_addr == rd_addr) ? wr_data : mem_reg[rd_addr];
        end
    end

    assign rd_data = rd_data_reg;

endmodule : srcel_mem

/* File: logic/srcel_fifo.sv */
`include "srcel_defines.svh"

module srcel_fifo
    import srcel_pkg::*;
#(
    parameter int W = `SRCEL_CMD_W,
    parameter int D = `SRCEL_FIFO_DEPTH
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [$clog2(D):0] level
);

    localparam int AW = $clog2(D);
    localparam logic [AW:0] FULL = (AW + 1)'(D);

    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] cnt_reg;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    wire [AW-1:0] rd_ptr_next = pop ? AW'(rd_ptr_reg + 1'h1) : rd_ptr_reg;
    wire [AW:0] cnt_next = (AW + 1)'(cnt_reg + (AW + 1)'(push) - (AW + 1)'(pop));

    assign in_ready = cnt_reg != FULL;
    assign out_valid = cnt_reg != '0;
    assign level = cnt_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg <= '0;
        end
        else
        begin
            wr_ptr_reg <= push ? AW'(wr_ptr_reg + 1'h1) : wr_ptr_reg;
            rd_ptr_reg <= rd_ptr_next;
            cnt_reg <= cnt_next;
        end
    end

    srcel_mem #(
        .W(W),
        .D(D),
        .AW(AW)
    ) u_mem (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(push),
        .wr_addr(wr_ptr_reg),
        .wr_data(in_data),
        .rd_addr(rd_ptr_next),
        .rd_data(out_data)
    );

endmodule : srcel_fifo

/* File: logic/srcel_top.sv */
// The address map and the APB interface to the registers are this design's own decisions.
`include "srcel_defines.svh"

module srcel_top
    import srcel_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`SRCEL_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic shift_strobe,
    input wire logic serial_feed,
    input wire logic [`SRCEL_STAGES-1:0] par_in,
    input wire logic sync_load,
    input wire logic async_load_n,
    input wire logic freeze_ctl,
    input wire logic scan_in,
    input wire logic scan_clk_a,
    input wire logic scan_clk_b,
    output logic [`SRCEL_STAGES-1:0] sipo_q,
    output logic [`SRCEL_STAGES-1:0] sload_q,
    output logic [`SRCEL_STAGES-1:0] aload_q,
    output logic [`SRCEL_STAGES-1:0] scan_q
);

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ============================================================
    // Pin synchronisers
    wire [`SRCEL_PIN_W-1:0] pin_raw = {scan_clk_b, scan_clk_a, scan_in, freeze_ctl,
        async_load_n, sync_load, par_in, serial_feed, shift_strobe};
    wire [`SRCEL_PIN_W-1:0] pin_s;
    localparam logic [`SRCEL_PIN_W-1:0] PIN_RST = `SRCEL_PIN_RST;

    genvar gi;
    generate
        for (gi = 0; gi < `SRCEL_PIN_W; gi++)
        begin : g_sync
            logic meta_reg;
            logic sync_reg;
            // The load pin idles high so that reset does not look like a parallel load.
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    meta_reg <= PIN_RST[gi];
                    sync_reg <= PIN_RST[gi];
                end
                else
                begin
                    meta_reg <= pin_raw[gi];
                    sync_reg <= meta_reg;
                end
            end
            assign pin_s[gi] = sync_reg;
        end
    endgenerate

    wire strobe_s = pin_s[`SRCEL_PIN_STROBE];
    wire ser_s = pin_s[`SRCEL_PIN_SER];
    wire [`SRCEL_STAGES-1:0] par_s = pin_s[`SRCEL_PIN_PAR_HI:`SRCEL_PIN_PAR_LO];
    wire sload_s = pin_s[`SRCEL_PIN_SLOAD];
    wire aload_n_s = pin_s[`SRCEL_PIN_ALOAD_N];
    wire freeze_s = pin_s[`SRCEL_PIN_FREEZE];
    wire scan_in_s = pin_s[`SRCEL_PIN_SCAN_IN];
    wire scan_a_s = pin_s[`SRCEL_PIN_SCAN_A];
    wire scan_b_s = pin_s[`SRCEL_PIN_SCAN_B];

    // ============================================================
    // Edge detection
    logic strobe_d_reg;
    logic scan_a_d_reg;
    logic scan_b_d_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            strobe_d_reg <= 1'h0;
            scan_a_d_reg <= 1'h0;
            scan_b_d_reg <= 1'h0;
        end
        else
        begin
            strobe_d_reg <= strobe_s;
            scan_a_d_reg <= scan_a_s;
            scan_b_d_reg <= scan_b_s;
        end
    end

    wire fall = strobe_d_reg && !strobe_s;
    wire a_rise = scan_a_s && !scan_a_d_reg;
    wire b_rise = scan_b_s && !scan_b_d_reg;

    // ============================================================
    // Command FIFO and source selection
    logic ctrl_reg;
    logic acc;
    wire hit_cmd;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [`SRCEL_CMD_W-1:0] fifo_out;
    wire [`SRCEL_CNT_W-1:0] fifo_level;

    // Commands drain only on strobe edges, so a slow strobe lets the FIFO fill and stall the bus.
    srcel_fifo #(
        .W(`SRCEL_CMD_W),
        .D(`SRCEL_FIFO_DEPTH)
    ) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(acc && pwrite && hit_cmd),
        .in_ready(fifo_in_ready),
        .in_data(pwdata[`SRCEL_CMD_W-1:0]),
        .out_valid(fifo_out_valid),
        .out_ready(fall && ctrl_reg),
        .out_data(fifo_out),
        .level(fifo_level)
    );

    // With the FIFO selected but empty, the pins feed the cells so no edge is lost.
    wire use_fifo = ctrl_reg && fifo_out_valid;
    wire sel_ser = use_fifo ? fifo_out[`SRCEL_CMD_SER] : ser_s;
    wire [`SRCEL_STAGES-1:0] sel_par = use_fifo ? fifo_out[`SRCEL_CMD_PAR_HI:`SRCEL_CMD_PAR_LO] : par_s;
    wire sel_load = use_fifo ? fifo_out[`SRCEL_CMD_LOAD] : sload_s;

    // ============================================================
    // Serial-in parallel-out cell
    srcel_stage_t sipo_reg;
    srcel_stage_t sipo_next;
    srcel_stage_t sload_reg;
    srcel_stage_t sload_next;
    srcel_stage_t aload_reg;
    srcel_stage_t aload_next;
    srcel_stage_t scan_reg;
    srcel_stage_t scan_next;
    srcel_stage_t scan_mst_reg;

    assign sipo_next = fall ? {sipo_reg[2:0], sel_ser} : sipo_reg;

    a_sipo_shift: assert property (fall |=> sipo_reg == {$past(sipo_reg[2:0]), $past(sel_ser)})
        else $error("serial cell did not shift on the strobe edge");

    a_sipo_hold: assert property (!fall |=> $stable(sipo_reg))
        else $error("serial cell moved without a strobe edge");

    // ============================================================
    // Synchronous-load cell
    wire [`SRCEL_STAGES-1:0] sload_shift = {sload_reg[2:0], sel_ser};
    wire [`SRCEL_STAGES-1:0] sload_pick = sel_load ? sel_par : sload_shift;

    assign sload_next = fall ? sload_pick : sload_reg;

    a_sload_load: assert property (fall && sel_load |=> sload_reg == $past(sel_par))
        else $error("synchronous load did not capture the parallel word");

    a_sload_shift: assert property (fall && !sel_load |=> sload_reg == {$past(sload_reg[2:0]), $past(sel_ser)})
        else $error("synchronous-load cell did not shift serially");

    // ============================================================
    // Asynchronous-load cell
    // The load acts every pclk cycle while low, so after the synchroniser it follows par_in
    // with a fixed latency instead of a true transparent path.
    wire [`SRCEL_STAGES-1:0] aload_shift = {aload_reg[2:0], sel_ser};
    wire [`SRCEL_STAGES-1:0] aload_clk = fall ? aload_shift : aload_reg;

    assign aload_next = !aload_n_s ? par_s : aload_clk;

    sequence s_aload_held;
        !aload_n_s [*2];
    endsequence

    a_aload_follow: assert property (s_aload_held |-> aload_reg == $past(par_s))
        else $error("asynchronous-load cell did not follow the parallel inputs");

    a_aload_shift: assert property (aload_n_s && fall |=> aload_reg == {$past(aload_reg[2:0]), $past(sel_ser)})
        else $error("asynchronous-load cell did not shift with load high");

    // ============================================================
    // Scan cell
    // Scan clock A captures the shifted pattern into a master stage and B transfers it, so
    // the two clocks must not rise together; freeze_ctl blocks only the shift strobe.
    wire scan_run = fall && !freeze_s;
    wire [`SRCEL_STAGES-1:0] scan_shift = {scan_reg[2:0], sel_ser};
    wire [`SRCEL_STAGES-1:0] scan_clk = scan_run ? scan_shift : scan_reg;

    assign scan_next = b_rise ? scan_mst_reg : scan_clk;

    sequence s_scan_transfer;
        a_rise ##[1:8] b_rise;
    endsequence

    a_scan_freeze: assert property (freeze_s && !b_rise |=> $stable(scan_reg))
        else $error("scan cell moved while frozen");

    a_scan_path: assert property (s_scan_transfer |=> scan_reg == $past(scan_mst_reg))
        else $error("scan transfer did not reach the stages");

    // ============================================================
    // Stage registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sipo_reg <= `SRCEL_STAGE_RST;
            sload_reg <= `SRCEL_STAGE_RST;
            aload_reg <= `SRCEL_STAGE_RST;
        end
        else
        begin
            sipo_reg <= sipo_next;
            sload_reg <= sload_next;
            aload_reg <= aload_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            scan_reg <= `SRCEL_STAGE_RST;
            scan_mst_reg <= `SRCEL_STAGE_RST;
        end
        else
        begin
            scan_reg <= scan_next;
            scan_mst_reg <= a_rise ? {scan_reg[2:0], scan_in_s} : scan_mst_reg;
        end
    end

    assign sipo_q = sipo_reg;
    assign sload_q = sload_reg;
    assign aload_q = aload_reg;
    assign scan_q = scan_reg;

    // ============================================================
    // APB slave
    srcel_bus_state_t bus_reg;
    srcel_bus_state_t bus_next;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;

    wire hit_ctrl = paddr == `SRCEL_OFF_CTRL;
    assign hit_cmd = paddr == `SRCEL_OFF_CMD;
    wire hit_stat = paddr == `SRCEL_OFF_STAT;
    wire hit_level = paddr == `SRCEL_OFF_LEVEL;
    wire hit_any = hit_ctrl || hit_cmd || hit_stat || hit_level;
    wire cmd_stall = pwrite && hit_cmd && !fifo_in_ready;
    wire req = psel && penable && bus_reg == SRCEL_BUS_IDLE;
    wire take = req && !cmd_stall;

    assign acc = psel && penable && bus_reg == SRCEL_BUS_ACK;

    wire [31:0] rd_word = hit_ctrl ? 32'(ctrl_reg) :
        hit_stat ? {16'h0000, scan_reg, aload_reg, sload_reg, sipo_reg} :
        hit_level ? 32'(fifo_level) : `SRCEL_WORD_ZERO;

    always_comb
    begin
        case (bus_reg)
            SRCEL_BUS_IDLE: bus_next = take ? SRCEL_BUS_ACK : SRCEL_BUS_IDLE;
            SRCEL_BUS_ACK: bus_next = SRCEL_BUS_IDLE;
            default: bus_next = SRCEL_BUS_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bus_reg <= SRCEL_BUS_IDLE;
            pready_reg <= 1'h0;
        end
        else
        begin
            bus_reg <= bus_next;
            pready_reg <= take;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_reg <= `SRCEL_WORD_ZERO;
            pslverr_reg <= 1'h0;
        end
        else if (take)
        begin
            prdata_reg <= pwrite ? `SRCEL_WORD_ZERO : rd_word;
            pslverr_reg <= !hit_any;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg <= `SRCEL_CTRL_RST;
        end
        else if (acc && pwrite && hit_ctrl)
        begin
            ctrl_reg <= pwdata[`SRCEL_CTRL_SRC_BIT];
        end
    end

    a_bus_stall: assert property (req && cmd_stall |=> !pready_reg)
        else $error("command write answered while the FIFO was full");

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;

endmodule : srcel_top

/* File: tb/srcel_pins.sv */
module srcel_pins
(
    input wire logic pclk,
    output logic shift_strobe,
    output logic serial_feed,
    output logic [3:0] par_in,
    output logic sync_load,
    output logic async_load_n,
    output logic freeze_ctl,
    output logic scan_in,
    output logic scan_clk_a,
    output logic scan_clk_b
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        shift_strobe = 1'b0;
        serial_feed = 1'b0;
        par_in = 4'h0;
        sync_load = 1'b0;
        async_load_n = 1'b1;
        freeze_ctl = 1'b0;
        scan_in = 1'b0;
        scan_clk_a = 1'b0;
        scan_clk_b = 1'b0;
    end

    // ============================================================
    // Pin sequences of the user logic
    // The strobe idles low; each pulse is 3 cycles high and 5 low, so the synchroniser never misses it.
    task shift(input logic s, input logic [3:0] p, input logic ld);
        @(posedge pclk);
        serial_feed <= s;
        par_in <= p;
        sync_load <= ld;
        shift_strobe <= 1'b1;
        repeat (3) @(posedge pclk);
        shift_strobe <= 1'b0;
        repeat (5) @(posedge pclk);
        // The data lines move away once the hold is over, so stale values cannot pass for a match.
        serial_feed <= ~s;
        par_in <= ~p;
        sync_load <= ~ld;
    endtask : shift

    task scan(input logic s);
        @(posedge pclk);
        scan_in <= s;
        scan_clk_a <= 1'b1;
        repeat (3) @(posedge pclk);
        scan_clk_a <= 1'b0;
        repeat (3) @(posedge pclk);
        scan_clk_b <= 1'b1;
        repeat (3) @(posedge pclk);
        scan_clk_b <= 1'b0;
        repeat (5) @(posedge pclk);
        scan_in <= ~s;
    endtask : scan

    task set_ctl(input logic frz, input logic aload_n);
        @(posedge pclk);
        freeze_ctl <= frz;
        async_load_n <= aload_n;
    endtask : set_ctl
endmodule : srcel_pins

/* File: tb/tb_srcel_top.sv */
`include "srcel_defines.svh"

module tb_srcel_top
    import srcel_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {logic s; logic [3:0] p; logic ld; logic [3:0] qs; logic [3:0] ql;} srcel_row_t;
    srcel_row_t rows [7] = '{'{1'b1, 4'hA, 1'b0, 4'h1, 4'h1}, '{1'b0, 4'h5, 1'b1, 4'h2, 4'h5},
        '{1'b1, 4'hF, 1'b0, 4'h5, 4'hB}, '{1'b1, 4'h3, 1'b1, 4'hB, 4'h3}, '{1'b0, 4'h0, 1'b0, 4'h6, 4'h6},
        '{1'b1, 4'hC, 1'b0, 4'hD, 4'hD}, '{1'b0, 4'h9, 1'b0, 4'hA, 4'hA}};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr, ahold, frz;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rq;
    logic shift_strobe, serial_feed, sync_load, async_load_n, freeze_ctl, scan_in, scan_clk_a, scan_clk_b;
    logic [3:0] par_in;
    srcel_stage_t sipo_q, sload_q, aload_q, scan_q, es, el, ea, ec;
    int bad_count = 0;
    int n_checks = 0;
    int cyc = 0;

    srcel_top u_srcel_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .shift_strobe, .serial_feed, .par_in, .sync_load, .async_load_n, .freeze_ctl, .scan_in,
        .scan_clk_a, .scan_clk_b, .sipo_q, .sload_q, .aload_q, .scan_q);
    srcel_pins u_srcel_pins (.pclk, .shift_strobe, .serial_feed, .par_in, .sync_load, .async_load_n,
        .freeze_ctl, .scan_in, .scan_clk_a, .scan_clk_b);

    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            bad_count++;
            finish_test();
        end
    end

    // ============================================================
    // Shared tasks
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rq = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // One strobe pulse, then every cell against the reference; inv drives the pins opposite to it.
    task step(input logic s, input logic [3:0] p, input logic ld, input logic inv);
        u_srcel_pins.shift(s ^ inv, p ^ {4{inv}}, ld ^ inv);
        es = {es[2:0], s};
        el = ld ? p : {el[2:0], s};
        ea = ahold ? p : {ea[2:0], s};
        if (!frz)
            ec = {ec[2:0], s};
        @(negedge pclk);
        check(sipo_q, es);
        check(sload_q, el);
        check(aload_q, ea);
        check(scan_q, ec);
    endtask : step

    task finish_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test

    // ============================================================
    // Main sequence
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        ahold = 1'b0;
        frz = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        check({sipo_q, sload_q, aload_q, scan_q}, 32'h0000_0000);
        apb(1'b0, `SRCEL_OFF_CTRL, 32'h0000_0000);
        check(rq, 32'h0000_0000);
        apb(1'b0, `SRCEL_OFF_CMD, 32'h0000_0000);
        check(rq, 32'h0000_0000);
        $display("test reset done");
        foreach (rows[i])
        begin
            u_srcel_pins.shift(rows[i].s, rows[i].p, rows[i].ld);
            @(negedge pclk);
            check(sipo_q, rows[i].qs);
            check(sload_q, rows[i].ql);
            check(aload_q, rows[i].qs);
            check(scan_q, rows[i].qs);
        end
        {es, el, ea, ec} = 16'hAAAA;
        $display("test rows done");
        apb(1'b0, `SRCEL_OFF_STAT, 32'h0000_0000);
        check(rq, 32'h0000_AAAA);
        apb(1'b1, 12'h010, 32'hFFFF_FFFF);
        check(rerr, 1'b1);
        apb(1'b0, 12'h010, 32'h0000_0000);
        check(rq, 32'h0000_0000);
        apb(1'b1, `SRCEL_OFF_CTRL, 32'h0000_0001);
        apb(1'b0, `SRCEL_OFF_CTRL, 32'h0000_0000);
        check(rq, 32'h0000_0001);
        check(rerr, 1'b0);
        apb(1'b1, `SRCEL_OFF_CTRL, 32'h0000_0000);
        $display("test registers done");
        ahold = 1'b1;
        u_srcel_pins.set_ctl(1'b0, 1'b0);
        step(1'b1, 4'h6, 1'b0, 1'b0);
        repeat (6) @(posedge pclk);
        @(negedge pclk);
        check(aload_q, 4'h9);
        ahold = 1'b0;
        ea = 4'h9;
        frz = 1'b1;
        u_srcel_pins.set_ctl(1'b1, 1'b1);
        step(1'b0, 4'h3, 1'b0, 1'b0);
        frz = 1'b0;
        u_srcel_pins.set_ctl(1'b0, 1'b1);
        u_srcel_pins.scan(1'b1);
        ec = {ec[2:0], 1'b1};
        @(negedge pclk);
        check(scan_q, ec);
        $display("test load and scan done");
        for (int k = 0; k < 16; k++)
            apb(1'b1, `SRCEL_OFF_CMD, {26'h0, 1'(k >> 1), 4'(k), 1'(k)});
        apb(1'b0, `SRCEL_OFF_LEVEL, 32'h0000_0000);
        check(rq, 32'h0000_0010);
        apb(1'b1, `SRCEL_OFF_CTRL, 32'h0000_0001);
        fork
            apb(1'b1, `SRCEL_OFF_CMD, 32'h0000_0000);
            begin
                repeat (8) @(posedge pclk);
                @(negedge pclk);
                check(pready, 1'b0);
                step(1'b0, 4'h0, 1'b0, 1'b1);
            end
        join
        for (int k = 1; k < 17; k++)
            step(k[0], k[3:0], k[1], 1'b1);
        apb(1'b0, `SRCEL_OFF_LEVEL, 32'h0000_0000);
        check(rq, 32'h0000_0000);
        step(1'b1, 4'hC, 1'b1, 1'b0);
        $display("test buffer done");
        // A reset in mid-run must clear the cells and the source select left at one.
        @(posedge pclk);
        presetn <= 1'b0;
        @(negedge pclk);
        check({sipo_q, sload_q, aload_q, scan_q}, 32'h0000_0000);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        {es, el, ea, ec} = 16'h0000;
        step(1'b1, 4'h5, 1'b1, 1'b0);
        apb(1'b0, `SRCEL_OFF_CTRL, 32'h0000_0000);
        check(rq, 32'h0000_0000);
        $display("test mid-run reset done");
        finish_test();
    end
endmodule : tb_srcel_top
